// File: src/ned_pkg.sv
// Overview of operation
// - Add immediate to accumulator, carry untouched; skip next when no overflow.
// - AND and OR combine accumulator with addressed RAM nibble into accumulator.
// - Set-carry and clear-carry instructions each finish in one cycle.
// - Skip next instruction when carry is zero; carry unchanged.
// - Complement replaces the accumulator with its bitwise inverse.
// - Rotate carry and accumulator right by one through the carry.
// - Set or clear bit j of the addressed RAM nibble.
// - Skip next instruction when bit j of addressed RAM nibble is zero.
// - Skip next instruction when accumulator equals addressed RAM nibble.
// - Two-word compare with immediate in second word; skip on equality.
// - Near branch loads seven low address bits, page kept.
// - Far branch loads page and low address over two words, two cycles.
// - Indirect far branch targets D register bits above accumulator in page.
// - Short call pushes return address and jumps into page two.
// - Far calls push return address and jump to immediate or indirect target.
// - Page field valid up to 63, or 47 on the smaller ROM.
// - Interrupt return pops address and restores saved context.
// - Subroutine return pops the address, two cycles.
// - Return and skip pops, then always skips the instruction returned to.
// - Interrupt disable clears and enable sets the global enable flag.
// - External flag test skips when flag is one, then clears it.
// - Pin level test skips when pin level matches control bit two.
// - Pair write loads timer 1, 2 or 4 counter and reload together.
// - Separate writes load only the timer 4 counter or only its reload.
// - Timer flag test skips when flag is one, then clears it.
package ned_pkg;
	localparam int         PCL_W     = 7;
	localparam int         PG_W      = 6;
	localparam int         PC_W      = 13;
	localparam int         SP_W      = 3;
	localparam logic [9:0] M_N       = 10'h3f0;
	localparam logic [9:0] M_J       = 10'h3fc;
	localparam logic [9:0] M_A7      = 10'h380;
	localparam logic [9:0] M_P5      = 10'h3e0;
	localparam logic [9:0] OP_ADDI   = 10'h060;
	localparam logic [9:0] OP_AND    = 10'h018;
	localparam logic [9:0] OP_OR     = 10'h019;
	localparam logic [9:0] OP_SETC   = 10'h007;
	localparam logic [9:0] OP_CLRC   = 10'h006;
	localparam logic [9:0] OP_SZC    = 10'h02f;
	localparam logic [9:0] OP_CMA    = 10'h01c;
	localparam logic [9:0] OP_ROR    = 10'h01d;
	localparam logic [9:0] OP_SETB   = 10'h05c;
	localparam logic [9:0] OP_CLRB   = 10'h04c;
	localparam logic [9:0] OP_SZB    = 10'h020;
	localparam logic [9:0] OP_SEQM   = 10'h026;
	localparam logic [9:0] OP_SEQI   = 10'h025;
	localparam logic [9:0] OP_NEAR   = 10'h180;
	localparam logic [9:0] OP_CALL2  = 10'h100;
	localparam logic [9:0] OP_FJMP   = 10'h0e0;
	localparam logic [9:0] OP_FCALL  = 10'h0c0;
	localparam logic [9:0] OP_FJMPI  = 10'h010;
	localparam logic [9:0] OP_FCALLI = 10'h030;
	localparam logic [9:0] OP_IRET   = 10'h046;
	localparam logic [9:0] OP_RET    = 10'h044;
	localparam logic [9:0] OP_RETS   = 10'h045;
	localparam logic [9:0] OP_IMASK  = 10'h004;
	localparam logic [9:0] OP_IUNM   = 10'h005;
	localparam logic [9:0] OP_SNZX   = 10'h038;
	localparam logic [9:0] OP_T1LD   = 10'h230;
	localparam logic [9:0] OP_T2LD   = 10'h231;
	localparam logic [9:0] OP_T4LD   = 10'h233;
	localparam logic [9:0] OP_T4CNT  = 10'h236;
	localparam logic [9:0] OP_T4RLD  = 10'h23c;
	localparam logic [9:0] OP_SNZT   = 10'h280;
	localparam logic [5:0] CALL_PAGE = 6'h02;
	localparam logic [5:0] PAGE_BIG  = 6'h3f;
	localparam logic [2:0] SP_RST    = 3'h7;
	localparam logic [3:0] NIB_RST   = 4'h0;
	localparam logic [12:0] PC_RST   = 13'h0000;
	typedef enum logic [1:0] {ST_EXEC, ST_W2, ST_SKIP2, ST_RET} ned_state_t;
endpackage : ned_pkg

// File: src/ned_stk_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ned_stk_if;
	logic        we;
	logic [2:0]  waddr;
	logic [12:0] wdata;
	logic [2:0]  raddr;
	logic [12:0] rdata;
	modport ctl (output we, output waddr, output wdata, output raddr,
		input rdata);
	modport mem (input we, input waddr, input wdata, input raddr,
		output rdata);
endinterface : ned_stk_if
`default_nettype wire

// File: src/ned_stack_mem.sv
`timescale 1ns/100ps
`default_nettype none
module ned_stack_mem #(
	parameter int DEPTH = 8
) (
	input  wire logic i_clk,   // System clock.
	ned_stk_if.mem    stk      // Stack port.
);
	logic [12:0] mem_r [DEPTH];
	logic [12:0] rdata_ff;

	// Writes forward to the read port so the registered top is never stale.
	always_ff @(posedge i_clk) begin
		if (stk.we) begin
			mem_r[stk.waddr] <= stk.wdata;
		end
		if (stk.we && stk.waddr == stk.raddr) begin
			rdata_ff <= stk.wdata;
		end else begin
			rdata_ff <= mem_r[stk.raddr];
		end
	end
	assign stk.rdata = rdata_ff;
endmodule : ned_stack_mem
`default_nettype wire

// File: src/ned_alu.sv
`timescale 1ns/100ps
`default_nettype none
module ned_alu (
	input  wire logic [3:0] i_acc,   // Accumulator.
	input  wire logic       i_cy,    // Carry bit.
	input  wire logic [3:0] i_mem,   // Addressed RAM nibble.
	input  wire logic [3:0] i_imm,   // Immediate nibble.
	input  wire logic [1:0] i_bsel,  // Bit index j.
	output logic [4:0]      o_sum,   // Acc plus immediate, with overflow.
	output logic [3:0]      o_and,   // Acc and memory.
	output logic [3:0]      o_or,    // Acc or memory.
	output logic [4:0]      o_ror,   // New carry, new acc.
	output logic [3:0]      o_setb,  // Memory with bit j set.
	output logic [3:0]      o_clrb,  // Memory with bit j cleared.
	output logic            o_bit    // Memory bit j.
);
	wire [3:0] onehot = 4'h1 << i_bsel;

	assign o_sum  = {1'b0, i_acc} + {1'b0, i_imm};
	assign o_and  = i_acc & i_mem;
	assign o_or   = i_acc | i_mem;
	assign o_ror  = {i_acc[0], i_cy, i_acc[3:1]};
	assign o_setb = i_mem | onehot;
	assign o_clrb = i_mem & ~onehot;
	assign o_bit  = i_mem[i_bsel];
endmodule : ned_alu
`default_nettype wire

// File: src/ned_exec.sv
`timescale 1ns/100ps
`default_nettype none
module ned_exec #(
	parameter logic [5:0] PAGE_MAX = ned_pkg::PAGE_BIG,
	parameter int         SK_DEPTH = 8
) (
	input  wire logic        i_clk,         // System clock.
	input  wire logic        i_sys_rst,     // Synchronous reset.
	input  wire logic        i_instr_valid, // Word at o_pc is present.
	input  wire logic [9:0]  i_instr,       // Instruction word.
	input  wire logic [3:0]  i_mem_rdata,   // RAM nibble at data pointer.
	input  wire logic [2:0]  i_d_reg,       // D register bits.
	input  wire logic        i_ab_we,       // External load of A and B.
	input  wire logic [7:0]  i_ab_wdata,    // B high, A low.
	input  wire logic [9:0]  i_data_pointer,// Current data pointer.
	input  wire logic        i_lds_state,   // Load suppression state.
	input  wire logic        i_irq_enter,   // Interrupt accepted.
	input  wire logic [12:0] i_irq_vector,  // Interrupt entry address.
	input  wire logic [1:0]  i_ext_req,     // External request pulses.
	input  wire logic [2:0]  i_ext_pin,     // Pins 0, 1, 2 (async).
	input  wire logic        i_pin0_ctl_b2, // Pin 0 level select.
	input  wire logic        i_pin1_ctl_b2, // Pin 1 level select.
	input  wire logic        i_pin_merge,   // Pin 1 or pin 2 merge.
	input  wire logic [3:0]  i_tmr_flag,    // Timer 1..4 flags.
	output logic             o_fetch_ready, // Ready to take a word this cycle.
	output logic [12:0]      o_pc,          // Program counter.
	output logic [3:0]       o_acc,         // Accumulator.
	output logic [3:0]       o_breg,        // Second working register.
	output logic             o_carry_bit,   // Carry bit.
	output logic [2:0]       o_stack_index, // Stack pointer.
	output logic             o_skip,        // Skip pending.
	output logic             o_irq_glb_en,  // Global interrupt enable.
	output logic [1:0]       o_ext_flag,    // External request flags.
	output logic             o_mem_we,      // RAM write strobe.
	output logic [3:0]       o_mem_wdata,   // RAM write nibble.
	output logic [7:0]       o_tmr_wdata,   // Timer write byte.
	output logic [2:0]       o_tmr_cnt_we,  // Counter load 1, 2, 4.
	output logic [2:0]       o_tmr_rld_we,  // Reload load 1, 2, 4.
	output logic [3:0]       o_tmr_flag_clr,// Timer flag clear.
	output logic             o_dp_restore,  // Restore pulse.
	output logic [9:0]       o_dp_value,    // Restored data pointer.
	output logic             o_lds_value,   // Restored suppression.
	output logic             o_page_err     // Page above PAGE_MAX.
);
	ned_pkg::ned_state_t st_ff, nxt_st;
	logic [12:0] pc_ff, nxt_pc;
	logic [3:0]  acc_ff, nxt_acc, b_ff, nxt_b;
	logic        cy_ff, nxt_cy, skip_ff, nxt_skip, ie_ff, nxt_ie;
	logic [2:0]  sp_ff, nxt_sp;
	logic [9:0]  op1_ff;
	logic        rdy_ff, memwe_ff, dpr_ff, perr_ff, nxt_perr;
	logic [3:0]  memwd_ff, nxt_memwd, tclr_ff;
	logic        nxt_memwe;
	logic [2:0]  cwe_ff, rwe_ff;
	logic [7:0]  twd_ff;
	logic [1:0]  xf_ff, xclr;
	logic [2:0]  pin_s1_ff, pin_s2_ff;
	logic [9:0]  sh_dp_ff;
	logic [3:0]  sh_a_ff, sh_b_ff;
	logic        sh_cy_ff, sh_sk_ff, sh_lds_ff;
	logic        push, pop;
	logic [12:0] push_val;

	ned_stk_if stk ();
	ned_stack_mem #(.DEPTH(SK_DEPTH)) u_stk (.i_clk(i_clk), .stk(stk));

	wire [9:0] w = i_instr;
	logic [4:0] sum, ror;
	logic [3:0] and_r, or_r, setb, clrb;
	logic       bit_j;
	ned_alu u_alu (
		.i_acc(acc_ff), .i_cy(cy_ff), .i_mem(i_mem_rdata),
		.i_imm(w[3:0]), .i_bsel(w[1:0]), .o_sum(sum), .o_and(and_r),
		.o_or(or_r), .o_ror(ror), .o_setb(setb), .o_clrb(clrb),
		.o_bit(bit_j)
	);

	// Pins are asynchronous; only the second stage is looked at.
	always_ff @(posedge i_clk) begin
		pin_s1_ff <= i_ext_pin;
		pin_s2_ff <= pin_s1_ff;
	end

	wire irq_go = i_irq_enter && st_ff == ned_pkg::ST_EXEC;
	wire take   = i_instr_valid && rdy_ff && !irq_go;
	wire at_ex  = take && st_ff == ned_pkg::ST_EXEC;
	wire ex     = at_ex && !skip_ff;
	wire at_w2  = take && st_ff == ned_pkg::ST_W2;
	wire [12:0] ret_addr = pc_ff + 13'h0001;

	wire is_addi  = (w & ned_pkg::M_N) == ned_pkg::OP_ADDI;
	wire is_and   = w == ned_pkg::OP_AND;
	wire is_or    = w == ned_pkg::OP_OR;
	wire is_setc  = w == ned_pkg::OP_SETC;
	wire is_clrc  = w == ned_pkg::OP_CLRC;
	wire is_szc   = w == ned_pkg::OP_SZC;
	wire is_cma   = w == ned_pkg::OP_CMA;
	wire is_ror   = w == ned_pkg::OP_ROR;
	wire is_setb  = (w & ned_pkg::M_J) == ned_pkg::OP_SETB;
	wire is_clrb  = (w & ned_pkg::M_J) == ned_pkg::OP_CLRB;
	wire is_szb   = (w & ned_pkg::M_J) == ned_pkg::OP_SZB;
	wire is_seqm  = w == ned_pkg::OP_SEQM;
	wire is_near  = (w & ned_pkg::M_A7) == ned_pkg::OP_NEAR;
	wire is_call2 = (w & ned_pkg::M_A7) == ned_pkg::OP_CALL2;
	wire is_iret  = w == ned_pkg::OP_IRET;
	wire is_ret   = w == ned_pkg::OP_RET;
	wire is_rets  = w == ned_pkg::OP_RETS;
	wire is_imask = w == ned_pkg::OP_IMASK;
	wire is_iunm  = w == ned_pkg::OP_IUNM;
	wire is_snzx  = (w & ned_pkg::M_J) == ned_pkg::OP_SNZX;
	wire is_snzt  = (w & ned_pkg::M_J) == ned_pkg::OP_SNZT;
	wire is_t4cnt = w == ned_pkg::OP_T4CNT;
	wire is_t4rld = w == ned_pkg::OP_T4RLD;
	wire [2:0] tld = {w == ned_pkg::OP_T4LD, w == ned_pkg::OP_T2LD,
		w == ned_pkg::OP_T1LD};
	wire is_fj    = (w & ned_pkg::M_P5) == ned_pkg::OP_FJMP;
	wire is_fc    = (w & ned_pkg::M_P5) == ned_pkg::OP_FCALL;
	wire is_two   = is_fj || is_fc || w == ned_pkg::OP_FJMPI
		|| w == ned_pkg::OP_FCALLI || w == ned_pkg::OP_SEQI;

	// Second-word decode looks at the held first word.
	wire h_fj  = (op1_ff & ned_pkg::M_P5) == ned_pkg::OP_FJMP;
	wire h_fc  = (op1_ff & ned_pkg::M_P5) == ned_pkg::OP_FCALL;
	wire h_fji = op1_ff == ned_pkg::OP_FJMPI;
	wire h_fci = op1_ff == ned_pkg::OP_FCALLI;
	wire h_seq = op1_ff == ned_pkg::OP_SEQI;
	wire [5:0] pg_dir = {w[7], op1_ff[4:0]};
	wire [5:0] pg_ind = {w[7:6], w[3:0]};
	wire [5:0] page   = (h_fj || h_fc) ? pg_dir : pg_ind;
	wire [6:0] low    = (h_fj || h_fc) ? w[6:0] : {i_d_reg, acc_ff};

	// Pin 1 may be merged with pin 2 by an OR.
	wire pin1_lvl = pin_s2_ff[1] || (i_pin_merge && pin_s2_ff[2]);
	wire pin0_hit = pin_s2_ff[0] == i_pin0_ctl_b2;
	wire pin1_hit = pin1_lvl == i_pin1_ctl_b2;
	wire [3:0] snzx_hit = {pin1_hit, pin0_hit, xf_ff};
	wire snzx_sk = snzx_hit[w[1:0]];
	wire snzt_sk = i_tmr_flag[w[1:0]];

	always_comb begin
		nxt_st    = st_ff;
		nxt_pc    = pc_ff;
		nxt_acc   = acc_ff;
		nxt_b     = b_ff;
		nxt_cy    = cy_ff;
		nxt_skip  = skip_ff;
		nxt_ie    = ie_ff;
		nxt_sp    = sp_ff;
		nxt_memwe = 1'b0;
		nxt_memwd = memwd_ff;
		nxt_perr  = 1'b0;
		xclr      = 2'h0;
		push      = 1'b0;
		pop       = 1'b0;
		push_val  = ret_addr;
		if (i_ab_we) begin
			{nxt_b, nxt_acc} = i_ab_wdata;
		end
		if (irq_go) begin
			push     = 1'b1;
			push_val = pc_ff;
			nxt_pc   = i_irq_vector;
			nxt_skip = 1'b0;
			nxt_ie   = 1'b0;
		end
		if (take) begin
			nxt_pc = ret_addr;
		end
		case (st_ff)
		ned_pkg::ST_EXEC: begin
			if (at_ex && skip_ff) begin
				nxt_skip = 1'b0;
				if (is_two) begin
					nxt_st = ned_pkg::ST_SKIP2;
				end
			end else if (ex) begin
				if (is_two) begin
					nxt_st = ned_pkg::ST_W2;
				end
				if (is_addi) begin
					nxt_acc  = sum[3:0];
					nxt_skip = !sum[4];
				end
				if (is_and) begin
					nxt_acc = and_r;
				end
				if (is_or) begin
					nxt_acc = or_r;
				end
				if (is_setc || is_clrc) begin
					nxt_cy = is_setc;
				end
				if (is_szc) begin
					nxt_skip = !cy_ff;
				end
				if (is_cma) begin
					nxt_acc = ~acc_ff;
				end
				if (is_ror) begin
					{nxt_cy, nxt_acc} = ror;
				end
				if (is_setb || is_clrb) begin
					nxt_memwe = 1'b1;
					nxt_memwd = is_setb ? setb : clrb;
				end
				if (is_szb) begin
					nxt_skip = !bit_j;
				end
				if (is_seqm) begin
					nxt_skip = acc_ff == i_mem_rdata;
				end
				if (is_near) begin
					nxt_pc = {pc_ff[12:7], w[6:0]};
				end
				if (is_call2) begin
					push   = 1'b1;
					nxt_pc = {ned_pkg::CALL_PAGE, w[6:0]};
				end
				if (is_ret || is_rets || is_iret) begin
					pop    = 1'b1;
					nxt_pc = stk.rdata;
				end
				if (is_ret || is_rets) begin
					nxt_st   = ned_pkg::ST_RET;
					nxt_skip = is_rets;
				end
				if (is_iret) begin
					nxt_acc  = sh_a_ff;
					nxt_b    = sh_b_ff;
					nxt_cy   = sh_cy_ff;
					nxt_skip = sh_sk_ff;
				end
				if (is_imask || is_iunm) begin
					nxt_ie = is_iunm;
				end
				if (is_snzx) begin
					nxt_skip = snzx_sk;
					xclr[0]  = w[1:0] == 2'h0 && xf_ff[0];
					xclr[1]  = w[1:0] == 2'h1 && xf_ff[1];
				end
				if (is_snzt) begin
					nxt_skip = snzt_sk;
				end
			end
		end
		ned_pkg::ST_W2: begin
			if (at_w2) begin
				nxt_st = ned_pkg::ST_EXEC;
				if (h_seq) begin
					nxt_skip = acc_ff == w[3:0];
				end else begin
					nxt_pc   = {page, low};
					push     = h_fc || h_fci;
					nxt_perr = page > PAGE_MAX;
				end
			end
		end
		ned_pkg::ST_SKIP2: begin
			if (take) begin
				nxt_st = ned_pkg::ST_EXEC;
			end
		end
		ned_pkg::ST_RET: begin
			nxt_st = ned_pkg::ST_EXEC;
		end
		default: begin
			nxt_st = ned_pkg::ST_EXEC;
		end
		endcase
		if (push) begin
			nxt_sp = sp_ff + 3'h1;
		end else if (pop) begin
			nxt_sp = sp_ff - 3'h1;
		end
	end

	assign stk.we    = push;
	assign stk.waddr = nxt_sp;
	assign stk.wdata = push_val;
	assign stk.raddr = nxt_sp;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_ff   <= ned_pkg::ST_EXEC;
			pc_ff   <= ned_pkg::PC_RST;
			acc_ff  <= ned_pkg::NIB_RST;
			b_ff    <= ned_pkg::NIB_RST;
			cy_ff   <= 1'b0;
			skip_ff <= 1'b0;
			ie_ff   <= 1'b0;
			sp_ff   <= ned_pkg::SP_RST;
			rdy_ff  <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			pc_ff   <= nxt_pc;
			acc_ff  <= nxt_acc;
			b_ff    <= nxt_b;
			cy_ff   <= nxt_cy;
			skip_ff <= nxt_skip;
			ie_ff   <= nxt_ie;
			sp_ff   <= nxt_sp;
			rdy_ff  <= nxt_st != ned_pkg::ST_RET;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			op1_ff   <= 10'h000;
			memwe_ff <= 1'b0;
			memwd_ff <= ned_pkg::NIB_RST;
			perr_ff  <= 1'b0;
			xf_ff    <= 2'h0;
		end else begin
			if (at_ex) begin
				op1_ff <= w;
			end
			memwe_ff <= nxt_memwe;
			memwd_ff <= nxt_memwd;
			perr_ff  <= nxt_perr;
			// A request arriving with the clear keeps the flag set.
			xf_ff <= (xf_ff & ~xclr) | i_ext_req;
		end
	end

	// Timer strobes; the timers own their flags and honour a set first.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cwe_ff  <= 3'h0;
			rwe_ff  <= 3'h0;
			twd_ff  <= 8'h00;
			tclr_ff <= 4'h0;
		end else begin
			cwe_ff  <= ex ? (tld | {is_t4cnt, 2'h0}) : 3'h0;
			rwe_ff  <= ex ? (tld | {is_t4rld, 2'h0}) : 3'h0;
			twd_ff  <= {b_ff, acc_ff};
			tclr_ff <= (ex && is_snzt) ? (i_tmr_flag & (4'h1 << w[1:0]))
				: 4'h0;
		end
	end

	// Context saved on interrupt entry and given back by the return.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sh_dp_ff  <= 10'h000;
			sh_a_ff   <= ned_pkg::NIB_RST;
			sh_b_ff   <= ned_pkg::NIB_RST;
			sh_cy_ff  <= 1'b0;
			sh_sk_ff  <= 1'b0;
			sh_lds_ff <= 1'b0;
			dpr_ff    <= 1'b0;
		end else begin
			if (irq_go) begin
				sh_dp_ff  <= i_data_pointer;
				sh_a_ff   <= acc_ff;
				sh_b_ff   <= b_ff;
				sh_cy_ff  <= cy_ff;
				sh_sk_ff  <= skip_ff;
				sh_lds_ff <= i_lds_state;
			end
			dpr_ff <= ex && is_iret;
		end
	end

	assign o_fetch_ready  = rdy_ff;
	assign o_pc           = pc_ff;
	assign o_acc          = acc_ff;
	assign o_breg         = b_ff;
	assign o_carry_bit    = cy_ff;
	assign o_stack_index  = sp_ff;
	assign o_skip         = skip_ff;
	assign o_irq_glb_en   = ie_ff;
	assign o_ext_flag     = xf_ff;
	assign o_mem_we       = memwe_ff;
	assign o_mem_wdata    = memwd_ff;
	assign o_tmr_wdata    = twd_ff;
	assign o_tmr_cnt_we   = cwe_ff;
	assign o_tmr_rld_we   = rwe_ff;
	assign o_tmr_flag_clr = tclr_ff;
	assign o_dp_restore   = dpr_ff;
	assign o_dp_value     = sh_dp_ff;
	assign o_lds_value    = sh_lds_ff;
	assign o_page_err     = perr_ff;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_skip_armed;
		at_ex && skip_ff && is_two;
	endsequence
	a_addi_skip: assert property (ex && is_addi |=> skip_ff == !$past(sum[4])
		&& cy_ff == $past(cy_ff)) else $error("add skip wrong");
	a_carry_ops: assert property (ex && (is_setc || is_clrc)
		|=> cy_ff == $past(is_setc)) else $error("carry op wrong");
	a_cma_inv: assert property (ex && is_cma |=> acc_ff == ~$past(acc_ff))
		else $error("complement wrong");
	a_ror_chain: assert property (ex && is_ror |=> {cy_ff, acc_ff} ==
		{$past(acc_ff[0]), $past(cy_ff), $past(acc_ff[3:1])})
		else $error("rotate wrong");
	a_near_jump: assert property (ex && is_near |=> pc_ff ==
		{$past(pc_ff[12:7]), $past(w[6:0])}) else $error("near jump");
	a_call_page: assert property (ex && is_call2 |=> sp_ff ==
		$past(sp_ff) + 3'h1 && pc_ff[12:7] == ned_pkg::CALL_PAGE)
		else $error("short call wrong");
	a_ret_cycles: assert property (ex && (is_ret || is_rets)
		|=> !rdy_ff ##1 rdy_ff) else $error("return not two cycles");
	a_skip_both: assert property (s_skip_armed |=> st_ff == ned_pkg::ST_SKIP2
		&& !skip_ff && acc_ff == $past(acc_ff)) else $error("skip two");
	a_xflag_hold: assert property (i_ext_req[0] |=> xf_ff[0])
		else $error("ext flag lost");
	a_timer_pair: assert property (ex && tld[0] |=> cwe_ff[0] && rwe_ff[0]
		&& twd_ff == $past({b_ff, acc_ff})) else $error("timer load");
endmodule : ned_exec
`default_nettype wire

// File: testbench/ned_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ned_mem_model (
	input  wire logic        i_clk,       // System clock.
	input  wire logic [12:0] i_pc,        // Fetch address.
	input  wire logic        i_mem_we,    // RAM write strobe.
	input  wire logic [3:0]  i_mem_wdata, // RAM write nibble.
	output logic [9:0]       o_instr,     // Word at fetch address.
	output logic [3:0]       o_mem_rdata  // Nibble at data pointer.
);
	logic [9:0] rom [0:8191];
	logic [3:0] ram_ff;
	// The ROM answers at once, so every word is valid when asked for.
	assign o_instr     = rom[i_pc];
	assign o_mem_rdata = ram_ff;
	always @(posedge i_clk) begin
		if (i_mem_we) begin
			ram_ff <= i_mem_wdata;
		end
	end
	task automatic wipe(input logic [3:0] nib);
		for (int k = 0; k < 8192; k++) begin
			rom[k] = 10'h000;
		end
		ram_ff = nib;
	endtask : wipe
endmodule : ned_mem_model
`default_nettype wire

// File: testbench/test_nibble_cpu_exec_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
	mismatches++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module test_nibble_cpu_exec_decoder;
	logic        i_clk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        ab_we = 1'b0;
	logic        irq_enter = 1'b0;
	logic [1:0]  ext_req = 2'h0;
	logic [3:0]  tmr_flag = 4'h0;
	logic [9:0]  instr;
	logic [3:0]  mem_rdata, acc, mem_wdata;
	logic [12:0] pc;
	logic [2:0]  sp;
	logic [1:0]  ext_flag;
	logic        carry, ie, mem_we, page_err;
	logic        instr_valid = 1'b1;
	logic [2:0]  pins = 3'h0;
	logic        pin0_ctl = 1'b0;
	logic        pin1_ctl = 1'b0;
	logic        pin_merge = 1'b0;
	logic [3:0]  tmr_clr;
	logic [3:0]  clr_seen = 4'h0;
	int          mismatches = 0;
	int          checks_done = 0;
	always #5 i_clk = ~i_clk;
	ned_exec u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_instr_valid(instr_valid), .i_instr(instr),
		.i_mem_rdata(mem_rdata),
		.i_d_reg(3'h5), .i_ab_we(ab_we), .i_ab_wdata(8'h00),
		.i_data_pointer(10'h000), .i_lds_state(1'b0),
		.i_irq_enter(irq_enter), .i_irq_vector(13'h0000),
		.i_ext_req(ext_req), .i_ext_pin(pins), .i_pin0_ctl_b2(pin0_ctl),
		.i_pin1_ctl_b2(pin1_ctl), .i_pin_merge(pin_merge),
		.i_tmr_flag(tmr_flag),
		.o_fetch_ready(), .o_pc(pc), .o_acc(acc), .o_breg(),
		.o_carry_bit(carry), .o_stack_index(sp), .o_skip(),
		.o_irq_glb_en(ie), .o_ext_flag(ext_flag), .o_mem_we(mem_we),
		.o_mem_wdata(mem_wdata), .o_tmr_wdata(), .o_tmr_cnt_we(),
		.o_tmr_rld_we(), .o_tmr_flag_clr(tmr_clr), .o_dp_restore(),
		.o_dp_value(), .o_lds_value(), .o_page_err(page_err));
	ned_mem_model u_mem (.i_clk(i_clk), .i_pc(pc), .i_mem_we(mem_we),
		.i_mem_wdata(mem_wdata), .o_instr(instr), .o_mem_rdata(mem_rdata));
	// Timer clears are remembered so that a lost pulse cannot hide.
	always @(posedge i_clk) begin
		clr_seen <= clr_seen | (i_sys_rst ? 4'h0 : tmr_clr);
	end
	// Resets, then loads a program at address zero on the clock after reset
	// is raised, the same edge at which a pending RAM write can still land.
	task automatic run(input logic [9:0] w[$], input logic [3:0] nib);
		@(posedge i_clk);
		i_sys_rst <= 1'b1;
		@(posedge i_clk);
		u_mem.wipe(nib);
		foreach (w[k]) begin
			u_mem.rom[k] = w[k];
		end
		i_sys_rst <= 1'b0;
	endtask : run
	task automatic finish_run(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : finish_run
	task automatic s_arith;
		run({10'h06c, 10'h06f, 10'h067, 10'h007, 10'h01d, 10'h01c,
			10'h02f, 10'h061, 10'h061, 10'h006, 10'h02f, 10'h0e1,
			10'h201, 10'h061}, 4'h0);
		finish_run(20);
		`CHK(acc, 4'h8)
		`CHK(carry, 1'b0)
	endtask : s_arith
	task automatic s_mem;
		run({10'h019, 10'h05c, 10'h000, 10'h04f, 10'h000, 10'h022,
			10'h061, 10'h018, 10'h026, 10'h061, 10'h000, 10'h026,
			10'h061, 10'h025, 10'h073, 10'h064}, 4'ha);
		finish_run(20);
		`CHK(acc, 4'h3)
		`CHK(u_mem.ram_ff, 4'h3)
	endtask : s_mem
	task automatic s_branch;
		run({10'h190}, 4'h0);
		u_mem.rom[13'h010] = 10'h105;
		u_mem.rom[13'h105] = 10'h045;
		u_mem.rom[13'h011] = 10'h061;
		u_mem.rom[13'h012] = 10'h0e3;
		u_mem.rom[13'h013] = 10'h220;
		u_mem.rom[13'h1a0] = 10'h062;
		finish_run(3);
		`CHK(pc, 13'h0105)
		`CHK(sp, 3'h0)
		finish_run(13);
		`CHK(acc, 4'h2)
		`CHK(sp, 3'h7)
		`CHK(page_err, 1'b0)
	endtask : s_branch
	task automatic s_flags;
		run({10'h000, 10'h000, 10'h038, 10'h061, 10'h280, 10'h061,
			10'h005, 10'h03a, 10'h061, 10'h03b, 10'h230, 10'h062},
			4'h0);
		instr_valid <= 1'b0;
		ext_req     <= 2'h1;
		tmr_flag    <= 4'h1;
		pins        <= 3'h5;
		pin0_ctl    <= 1'b1;
		pin_merge   <= 1'b1;
		@(posedge i_clk);
		ext_req <= 2'h0;
		// Two stalled fetches delay the flag test by two cycles.
		repeat (2) @(posedge i_clk);
		instr_valid <= 1'b1;
		finish_run(2);
		`CHK(ext_flag, 2'h1)
		finish_run(12);
		`CHK(acc, 4'h2)
		`CHK(ext_flag, 2'h0)
		`CHK(ie, 1'b1)
		`CHK(clr_seen, 4'h1)
		tmr_flag <= 4'h0;
	endtask : s_flags
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude
	initial begin
		s_arith();
		s_mem();
		s_branch();
		s_flags();
		conclude();
	end
endmodule : test_nibble_cpu_exec_decoder
`default_nettype wire
